//--- rtl/sccl_pkg.sv
// Shared constants for the serial character conversion and line control block.
// Assumes a single AHB-Lite slave on a 32-bit bus, zero wait on writes.
package sccl_pkg;

	// Register byte addresses.
	localparam logic [7:0] SCCL_ADDR_CTRL = 8'h00;
	localparam logic [7:0] SCCL_ADDR_CMD = 8'h04;
	localparam logic [7:0] SCCL_ADDR_STATUS = 8'h08;
	localparam logic [7:0] SCCL_ADDR_WSIZE = 8'h0C;
	localparam logic [7:0] SCCL_ADDR_TXIN = 8'h10;
	localparam logic [7:0] SCCL_ADDR_TXOUT = 8'h14;
	localparam logic [7:0] SCCL_ADDR_RXIN = 8'h18;
	localparam logic [7:0] SCCL_ADDR_RXOUT = 8'h1C;
	localparam logic [7:0] SCCL_ADDR_CFG0 = 8'h20;
	localparam logic [7:0] SCCL_ADDR_CFG1 = 8'h24;
	localparam logic [7:0] SCCL_ADDR_CFG2 = 8'h28;
	localparam logic [7:0] SCCL_ADDR_CFG3 = 8'h2C;
	localparam logic [7:0] SCCL_ADDR_LINES = 8'h30;

	// Command codes.
	localparam logic [7:0] SCCL_CMD_LINE_CTL = 8'h22;
	localparam logic [7:0] SCCL_CMD_XLATE_CFG = 8'h26;

	// Option sum field positions.
	localparam int SCCL_OPT_LF_BIT = 6;
	localparam int SCCL_OPT_TR_LSB = 4;
	localparam int SCCL_OPT_IP_LSB = 2;
	localparam int SCCL_OPT_OP_LSB = 0;
	localparam int SCCL_LC_DTR_LSB = 6;
	localparam int SCCL_LC_RTS_LSB = 4;
	localparam int SCCL_LC_XMT_LSB = 0;

	// Field encodings.
	localparam logic [1:0] SCCL_TR_LIGHT = 2'h0;
	localparam logic [1:0] SCCL_TR_HEAVY = 2'h1;
	localparam logic [1:0] SCCL_PAR_NONE = 2'h0;
	localparam logic [1:0] SCCL_PAR_ODD = 2'h1;
	localparam logic [1:0] SCCL_PAR_EVEN = 2'h2;
	localparam logic [1:0] SCCL_PAR_THIRD = 2'h3;
	localparam logic [1:0] SCCL_LC_OFF = 2'h2;
	localparam logic [1:0] SCCL_LC_ON = 2'h3;

	// Word size codes: 0 is 8 bits, 1 is 7, 2 is 6, 3 is 5.
	localparam logic [1:0] SCCL_WS_8 = 2'h0;
	localparam logic [1:0] SCCL_WS_7 = 2'h1;
	localparam logic [1:0] SCCL_WS_6 = 2'h2;

	// Character codes.
	localparam logic [7:0] SCCL_CH_EOL = 8'h9B;
	localparam logic [7:0] SCCL_CH_CR = 8'h0D;
	localparam logic [7:0] SCCL_CH_LF = 8'h0A;
	localparam logic [7:0] SCCL_CH_LOW_PRINT = 8'h20;
	localparam logic [7:0] SCCL_CH_HIGH_PRINT = 8'h7C;

	// Power-up line levels.
	localparam logic SCCL_MARK = 1'b1;
	localparam logic SCCL_LINE_OFF = 1'b0;

	typedef enum logic [0:0] {
		SCCL_BUS_IDLE = 1'b0,
		SCCL_BUS_RDWAIT = 1'b1
	} sccl_bus_t;

endpackage

//--- rtl/sccl_top.sv
// Four-port character conversion and outgoing line control, reached over AHB-Lite.
// Assumes it is the only slave, so hready_i is its own hreadyout_o.
//
// What this block does
// - Short outgoing words keep only the low bits.
// - Eight-bit words pass the size stage unchanged.
// - Short incoming words padded high with ones.
// - Translation command refused during concurrent transfer.
// - Option sum holds four fields; 32 means none.
// - Input parity: keep, odd, even, clear only.
// - Output parity: keep, odd, even, force one.
// - Option 64 adds line feed after translated return.
// - Second parameter is the heavy substitute character.
// - Per-port configuration defaults zero and persists.
// - System reset keeps stored translation configuration.
// - Port 1 all lines; 2,3 no RTS; 4 transmit only.
// - Control of a missing line is silently ignored.
// - Line command refused during concurrent transfer.
// - Transmit line idles MARK; break is long SPACE.
// - Power-up: DTR, RTS off, transmit line MARK.
// - System reset keeps line output states.
// - Line command code 34 sums three line fields.
// - Port designator 1 to 4, omitted means 1.
// - Output translate, parity, truncate; input reverse order.
// - Input parity error still delivers, sets flag.
// - Transmit field value 3 drives MARK.
`timescale 1ns/1ps

module sccl_top
	import sccl_pkg::*;
#(
	parameter int NUM_PORTS = 4
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_n_i,
	// AHB-Lite slave.
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	// Outgoing RS-232 lines.
	output logic [2:0] dtr_o,
	output logic rts_o,
	output logic [3:0] transmit_line_o
);

	initial begin
		if (NUM_PORTS != 4) begin
			$error("sccl_top serves exactly four ports");
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Character conversion functions.

	function automatic logic [7:0] trunc_word(input logic [7:0] c, input logic [1:0] ws);
		logic [7:0] r;
		r = c;
		unique case (ws)
			SCCL_WS_8: r = c;
			SCCL_WS_7: r = {1'b0, c[6:0]};
			SCCL_WS_6: r = {2'b00, c[5:0]};
			default: r = {3'b000, c[4:0]};
		endcase
		return r;
	endfunction

	function automatic logic [7:0] expand_word(input logic [7:0] c, input logic [1:0] ws);
		logic [7:0] r;
		r = c;
		unique case (ws)
			SCCL_WS_8: r = c;
			SCCL_WS_7: r = {1'b1, c[6:0]};
			SCCL_WS_6: r = {2'b11, c[5:0]};
			default: r = {3'b111, c[4:0]};
		endcase
		return r;
	endfunction

	function automatic logic [7:0] out_parity(input logic [7:0] c, input logic [1:0] mode);
		logic [7:0] r;
		r = c;
		unique case (mode)
			SCCL_PAR_NONE: r = c;
			SCCL_PAR_ODD: r = {~^c[6:0], c[6:0]};
			SCCL_PAR_EVEN: r = {^c[6:0], c[6:0]};
			default: r = {1'b1, c[6:0]};
		endcase
		return r;
	endfunction

	function automatic logic unprintable(input logic [7:0] c);
		return (c < SCCL_CH_LOW_PRINT) || (c > SCCL_CH_HIGH_PRINT);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Bus slave. Writes complete with no wait; reads take one wait state so that
	// read data comes from a flip-flop and always sees the previous write.

	logic addr_take;
	logic dp_wr_reg;
	logic [7:0] dp_addr_reg;
	sccl_bus_t bus_state_reg;
	logic [31:0] rdata_reg;
	logic [31:0] rd_mux;
	logic wr_en;

	assign addr_take = hsel_i & htrans_i[1] & hready_i;
	assign wr_en = dp_wr_reg;
	assign hreadyout_o = (bus_state_reg == SCCL_BUS_IDLE);
	assign hresp_o = 1'b0;
	assign hrdata_o = rdata_reg;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dp_wr_reg <= 1'b0;
			dp_addr_reg <= 8'h00;
		end else if (hready_i) begin
			dp_wr_reg <= addr_take & hwrite_i;
			dp_addr_reg <= {haddr_i[7:2], 2'b00};
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bus_state_reg <= SCCL_BUS_IDLE;
			rdata_reg <= 32'h0000_0000;
		end else begin
			unique case (bus_state_reg)
				SCCL_BUS_IDLE: begin
					if (addr_take && !hwrite_i) begin
						bus_state_reg <= SCCL_BUS_RDWAIT;
					end
				end
				SCCL_BUS_RDWAIT: begin
					bus_state_reg <= SCCL_BUS_IDLE;
					rdata_reg <= rd_mux;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Control, command and configuration state.

	logic concurrent_reg;
	logic sys_reset;
	logic rejected_reg;
	logic parity_err_reg;
	logic [7:0] wsize_reg;
	logic [7:0] opt_reg [4];
	logic [7:0] subst_reg [4];
	logic cmd_wr;
	logic [7:0] cmd_code;
	logic [2:0] cmd_port;
	logic [7:0] cmd_opt;
	logic [7:0] cmd_sub;
	logic [1:0] port_idx;
	logic port_bad;
	logic cmd_ok;
	logic rx_perr;

	assign cmd_wr = wr_en && (dp_addr_reg == SCCL_ADDR_CMD);
	assign cmd_code = hwdata_i[7:0];
	assign cmd_port = hwdata_i[10:8];
	assign cmd_opt = hwdata_i[23:16];
	assign cmd_sub = hwdata_i[31:24];
	assign sys_reset = wr_en && (dp_addr_reg == SCCL_ADDR_CTRL) && hwdata_i[1];

	assign port_idx = (cmd_port == 3'h0) ? 2'h0 : 2'(cmd_port - 3'h1);
	assign port_bad = (cmd_port > 3'h4);

	assign cmd_ok = !concurrent_reg && !port_bad &&
		((cmd_code == SCCL_CMD_XLATE_CFG) || (cmd_code == SCCL_CMD_LINE_CTL));

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			concurrent_reg <= 1'b0;
		end else if (sys_reset) begin
			concurrent_reg <= 1'b0;
		end else if (wr_en && (dp_addr_reg == SCCL_ADDR_CTRL)) begin
			concurrent_reg <= hwdata_i[0];
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rejected_reg <= 1'b0;
		end else if (sys_reset) begin
			rejected_reg <= 1'b0;
		end else if (cmd_wr) begin
			rejected_reg <= !cmd_ok;
		end
	end

	// A new error in the same cycle as a clear keeps the flag set.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			parity_err_reg <= 1'b0;
		end else if (rx_perr) begin
			parity_err_reg <= 1'b1;
		end else if (sys_reset) begin
			parity_err_reg <= 1'b0;
		end else if (wr_en && (dp_addr_reg == SCCL_ADDR_STATUS) && hwdata_i[1]) begin
			parity_err_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wsize_reg <= 8'h00;
		end else if (wr_en && (dp_addr_reg == SCCL_ADDR_WSIZE)) begin
			wsize_reg <= hwdata_i[7:0];
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int p = 0; p < 4; p++) begin
				opt_reg[p] <= 8'h00;
				subst_reg[p] <= 8'h00;
			end
		end else if (cmd_wr && cmd_ok && (cmd_code == SCCL_CMD_XLATE_CFG)) begin
			opt_reg[port_idx] <= cmd_opt;
			subst_reg[port_idx] <= cmd_sub;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outgoing lines. Only line commands and the power-up reset touch them.

	logic line_cmd;
	logic [1:0] dtr_f;
	logic [1:0] rts_f;
	logic [1:0] xmt_f;

	assign line_cmd = cmd_wr && cmd_ok && (cmd_code == SCCL_CMD_LINE_CTL);
	assign dtr_f = cmd_opt[SCCL_LC_DTR_LSB +: 2];
	assign rts_f = cmd_opt[SCCL_LC_RTS_LSB +: 2];
	assign xmt_f = cmd_opt[SCCL_LC_XMT_LSB +: 2];

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dtr_o <= {3{SCCL_LINE_OFF}};
			rts_o <= SCCL_LINE_OFF;
			transmit_line_o <= {4{SCCL_MARK}};
		end else if (line_cmd) begin
			// DTR on ports 1 to 3
			if (port_idx != 2'h3) begin
				if (dtr_f == SCCL_LC_OFF) begin
					dtr_o[port_idx] <= 1'b0;
				end else if (dtr_f == SCCL_LC_ON) begin
					dtr_o[port_idx] <= 1'b1;
				end
			end
			if (port_idx == 2'h0) begin
				if (rts_f == SCCL_LC_OFF) begin
					rts_o <= 1'b0;
				end else if (rts_f == SCCL_LC_ON) begin
					rts_o <= 1'b1;
				end
			end
			if (xmt_f == SCCL_LC_OFF) begin
				transmit_line_o[port_idx] <= 1'b0;
			end else if (xmt_f == SCCL_LC_ON) begin
				transmit_line_o[port_idx] <= SCCL_MARK;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outgoing character path: translate, add parity, then truncate.

	logic tx_wr;
	logic [1:0] tx_port;
	logic [7:0] tx_in;
	logic [7:0] tx_opt;
	logic [1:0] tx_ws;
	logic [7:0] tx_xl;
	logic [1:0] tx_cnt;
	logic [7:0] tx_ch0_reg;
	logic [7:0] tx_ch1_reg;
	logic [1:0] tx_cnt_reg;

	assign tx_wr = wr_en && (dp_addr_reg == SCCL_ADDR_TXIN);
	assign tx_port = hwdata_i[9:8];
	assign tx_in = hwdata_i[7:0];
	assign tx_opt = opt_reg[tx_port];
	assign tx_ws = wsize_reg[2*tx_port +: 2];

	always_comb begin
		tx_xl = tx_in;
		tx_cnt = 2'h1;
		if (tx_opt[SCCL_OPT_TR_LSB +: 2] <= SCCL_TR_HEAVY) begin
			if (tx_in == SCCL_CH_EOL) begin
				tx_xl = SCCL_CH_CR;
				tx_cnt = tx_opt[SCCL_OPT_LF_BIT] ? 2'h2 : 2'h1;
			end else if (tx_opt[SCCL_OPT_TR_LSB +: 2] == SCCL_TR_HEAVY) begin
				tx_cnt = unprintable(tx_in) ? 2'h0 : 2'h1;
			end else begin
				tx_xl = {1'b0, tx_in[6:0]};
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_ch0_reg <= 8'h00;
			tx_ch1_reg <= 8'h00;
			tx_cnt_reg <= 2'h0;
		end else if (tx_wr) begin
			tx_ch0_reg <= trunc_word(out_parity(tx_xl, tx_opt[SCCL_OPT_OP_LSB +: 2]), tx_ws);
			tx_ch1_reg <= (tx_cnt == 2'h2) ?
				trunc_word(out_parity(SCCL_CH_LF, tx_opt[SCCL_OPT_OP_LSB +: 2]), tx_ws) :
				8'h00;
			tx_cnt_reg <= tx_cnt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Incoming character path: expand, check parity, then translate.

	logic rx_wr;
	logic [1:0] rx_port;
	logic [7:0] rx_opt;
	logic [7:0] rx_exp;
	logic [7:0] rx_par;
	logic [7:0] rx_out;
	logic [1:0] rx_pm;
	logic [7:0] rx_ch_reg;
	logic rx_cerr_reg;

	assign rx_wr = wr_en && (dp_addr_reg == SCCL_ADDR_RXIN);
	assign rx_port = hwdata_i[9:8];
	assign rx_opt = opt_reg[rx_port];
	assign rx_pm = rx_opt[SCCL_OPT_IP_LSB +: 2];
	assign rx_exp = expand_word(hwdata_i[7:0], wsize_reg[2*rx_port +: 2]);

	always_comb begin
		rx_par = (rx_pm == SCCL_PAR_NONE) ? rx_exp : {1'b0, rx_exp[6:0]};
		rx_perr = rx_wr && (((rx_pm == SCCL_PAR_ODD) && !(^rx_exp)) ||
			((rx_pm == SCCL_PAR_EVEN) && (^rx_exp)));
		rx_out = rx_par;
		if (rx_opt[SCCL_OPT_TR_LSB +: 2] <= SCCL_TR_HEAVY) begin
			rx_out = {1'b0, rx_par[6:0]};
			if (rx_out == SCCL_CH_CR) begin
				rx_out = SCCL_CH_EOL;
			end else if ((rx_opt[SCCL_OPT_TR_LSB +: 2] == SCCL_TR_HEAVY) && unprintable(rx_out)) begin
				rx_out = subst_reg[rx_port];
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rx_ch_reg <= 8'h00;
			rx_cerr_reg <= 1'b0;
		end else if (rx_wr) begin
			rx_ch_reg <= rx_out;
			rx_cerr_reg <= rx_perr;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read data selection. Unmapped addresses read as zero.

	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (dp_addr_reg)
			SCCL_ADDR_CTRL: rd_mux = {31'h0, concurrent_reg};
			SCCL_ADDR_STATUS: rd_mux = {30'h0, parity_err_reg, rejected_reg};
			SCCL_ADDR_WSIZE: rd_mux = {24'h0, wsize_reg};
			SCCL_ADDR_TXOUT: rd_mux = {14'h0, tx_cnt_reg, tx_ch1_reg, tx_ch0_reg};
			SCCL_ADDR_RXOUT: rd_mux = {23'h0, rx_cerr_reg, rx_ch_reg};
			SCCL_ADDR_CFG0: rd_mux = {16'h0, subst_reg[0], opt_reg[0]};
			SCCL_ADDR_CFG1: rd_mux = {16'h0, subst_reg[1], opt_reg[1]};
			SCCL_ADDR_CFG2: rd_mux = {16'h0, subst_reg[2], opt_reg[2]};
			SCCL_ADDR_CFG3: rd_mux = {16'h0, subst_reg[3], opt_reg[3]};
			SCCL_ADDR_LINES: rd_mux = {24'h0, transmit_line_o, rts_o, dtr_o};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

endmodule

//--- bench/sccl_top_properties.sv
// Checker for the conversion and line-control block; sees only the top ports.
// Assumes one AHB-Lite slave, so hready_i follows hreadyout_o.
`timescale 1ns/1ps
module sccl_top_properties
	import sccl_pkg::*;
#(
	parameter int NUM_PORTS = 4
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	input wire logic [31:0] hrdata_o,
	input wire logic hreadyout_o,
	input wire logic hresp_o,
	input wire logic [2:0] dtr_o,
	input wire logic rts_o,
	input wire logic [3:0] transmit_line_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	logic wr_reg;
	logic conc_reg;
	logic [7:0] wa_reg;
	logic lc_dp;
	logic ok_dp;
	assign lc_dp = wr_reg && hready_i && wa_reg == SCCL_ADDR_CMD && hwdata_i[7:0] == 8'h22;
	assign ok_dp = lc_dp && !conc_reg;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_reg <= 1'b0;
			wa_reg <= 8'h00;
		end else if (hready_i) begin
			wr_reg <= hsel_i && htrans_i[1] && hwrite_i;
			wa_reg <= haddr_i[7:0];
		end
	end
	// Mirrors the concurrent flag; a system reset write clears it.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			conc_reg <= 1'b0;
		end else if (wr_reg && hready_i && wa_reg == SCCL_ADDR_CTRL) begin
			conc_reg <= hwdata_i[0] && !hwdata_i[1];
		end
	end
	sequence s_rd_req;
		hsel_i && htrans_i[1] && hready_i && !hwrite_i;
	endsequence
	sequence s_wr_req;
		hsel_i && htrans_i[1] && hready_i && hwrite_i;
	endsequence
	sequence s_one_wait;
		!hreadyout_o ##1 hreadyout_o;
	endsequence
	a_read_one_wait: assert property (s_rd_req |=> s_one_wait)
		else $error("read did not take exactly one wait");
	a_write_no_wait: assert property (s_wr_req |=> hreadyout_o)
		else $error("write was stalled");
	a_resp_okay: assert property (!hresp_o)
		else $error("slave response was not okay");
	a_lines_hold: assert property (
		!$stable({dtr_o, rts_o, transmit_line_o}) |-> $past(lc_dp))
		else $error("lines moved without a line command");
	a_refused_hold: assert property (
		lc_dp && conc_reg |=> $stable({dtr_o, rts_o, transmit_line_o}))
		else $error("line command acted during concurrent transfer");
	a_port4_tx_only: assert property (
		lc_dp && hwdata_i[10:8] == 3'h4 |=> $stable({dtr_o, rts_o, transmit_line_o[2:0]}))
		else $error("port 4 command touched another line");
	a_mid_no_rts: assert property (
		lc_dp && (hwdata_i[10:8] == 3'h2 || hwdata_i[10:8] == 3'h3) |=> $stable(rts_o))
		else $error("port 2 or 3 command moved rts");
	a_tx_space: assert property (
		ok_dp && hwdata_i[10:8] <= 3'h1 && hwdata_i[17:16] == 2'h2 |=> !transmit_line_o[0])
		else $error("port 1 transmit line not at space");
	a_tx_mark: assert property (
		ok_dp && hwdata_i[10:8] <= 3'h1 && hwdata_i[17:16] == 2'h3 |=> transmit_line_o[0])
		else $error("port 1 transmit line not at mark");
	a_dtr_on: assert property (
		ok_dp && hwdata_i[10:8] == 3'h2 && hwdata_i[23:22] == 2'h3 |=> dtr_o[1])
		else $error("port 2 dtr not on");
	a_rts_off: assert property (
		ok_dp && hwdata_i[10:8] <= 3'h1 && hwdata_i[21:20] == 2'h2 |=> !rts_o)
		else $error("port 1 rts not off");
endmodule
bind sccl_top sccl_top_properties #(.NUM_PORTS(NUM_PORTS)) u_props (.clk_i(clk_i),
	.rst_n_i(rst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
	.hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
	.hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .dtr_o(dtr_o),
	.rts_o(rts_o), .transmit_line_o(transmit_line_o));

//--- bench/sccl_rs232_peer.sv
// Far-end serial device model: watches the outgoing lines and notes breaks.
// Assumes the lines only move just after rising edges of clk_i.
`timescale 1ns/1ps
module sccl_rs232_peer #(
	parameter int WORD_CYCLES = 6
) (
	input wire logic clk_i,
	input wire logic [2:0] dtr_i,
	input wire logic rts_i,
	input wire logic [3:0] transmit_line_i,
	output logic [3:0] break_seen_o
);
	int space_cnt [4];
	initial break_seen_o = 4'h0;
	// break detection
	// Only a SPACE outlasting a whole word is a break; data bits never last that long.
	always @(posedge clk_i) begin
		for (int i = 0; i < 4; i++) begin
			space_cnt[i] = transmit_line_i[i] ? 0 : space_cnt[i] + 1;
			if (space_cnt[i] > WORD_CYCLES) break_seen_o[i] <= 1'b1;
		end
	end
endmodule

//--- bench/tb_sccl_top.sv
// Self-checking bench: AHB-Lite register tasks and table-driven scenarios.
// Assumes the single-slave wiring of hready_i to hreadyout_o.
`timescale 1ns/1ps
module tb_sccl_top;
	import sccl_pkg::*;
	logic clk_i;
	logic rst_n_i;
	logic hsel_i;
	logic [31:0] haddr_i;
	logic [1:0] htrans_i;
	logic hwrite_i;
	logic [31:0] hwdata_i;
	logic [31:0] hrdata_o;
	logic hreadyout_o;
	logic [2:0] dtr_o;
	logic rts_o;
	logic [3:0] transmit_line_o;
	logic [3:0] brk;
	logic [31:0] rd;
	int n_fail;
	int n_compared;
	int cycles;
	logic [23:0] tx_in [15] = '{24'h2000C5, 24'h2001FF, 24'h2002FF, 24'h2003FF, 24'h210003,
		24'h220007, 24'h230000, 24'h40009B, 24'h00009B, 24'h0000C1, 24'h10007D, 24'h10001F,
		24'h10007C, 24'h030141, 24'h42009B};
	logic [31:0] tx_exp [15] = '{32'h100C5, 32'h1007F, 32'h1003F, 32'h1001F, 32'h10083,
		32'h10087, 32'h10080, 32'h20A0D, 32'h1000D, 32'h10041, 32'h0, 32'h0, 32'h1007C,
		32'h10041, 32'h20A8D};
	logic [31:0] rx_in [13] = '{32'h20010500, 32'h20020500, 32'h20030500, 32'h20000500,
		32'h24008300, 32'h24000300, 32'h28000300, 32'h2C008000, 32'h20008300, 32'h00008D00,
		32'h1000072A, 32'h1000412A, 32'h28010600};
	logic [8:0] rx_exp [13] = '{9'h85, 9'hC5, 9'hE5, 9'h05, 9'h03, 9'h103, 9'h03, 9'h00,
		9'h83, 9'h9B, 9'h2A, 9'h41, 9'h106};
	logic [15:0] lc_in [8] = '{16'h01F2, 16'h0103, 16'h02F2, 16'h04C2, 16'h0403, 16'h01A0,
		16'h03C0, 16'h0002};
	logic [7:0] lc_exp [8] = '{8'hE9, 8'hF9, 8'hDB, 8'h5B, 8'hDB, 8'hD2, 8'hD6, 8'hC6};
	sccl_top #(.NUM_PORTS(4)) DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i),
		.haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
		.hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
		.hreadyout_o(hreadyout_o), .hresp_o(), .dtr_o(dtr_o), .rts_o(rts_o),
		.transmit_line_o(transmit_line_o));
	sccl_rs232_peer #(.WORD_CYCLES(6)) u_peer (.clk_i(clk_i), .dtr_i(dtr_o), .rts_i(rts_o),
		.transmit_line_i(transmit_line_o), .break_seen_o(brk));
	////////////////////////////////////////////////////////////////////////////////
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk_i);
		hsel_i <= 1'b1;
		haddr_i <= {24'h000000, a};
		htrans_i <= 2'h2;
		hwrite_i <= wr;
		do @(posedge clk_i); while (hreadyout_o !== 1'b1);
		hsel_i <= 1'b0;
		htrans_i <= 2'h0;
		hwdata_i <= wd;
		do @(posedge clk_i); while (hreadyout_o !== 1'b1);
		rd = hrdata_o;
	endtask
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string name);
		bus(1'b0, a, 32'h0);
		check(name, exp, rd);
	endtask
	task automatic cmd(input logic [7:0] c, input logic [2:0] p, input logic [15:0] args);
		bus(1'b1, SCCL_ADDR_CMD, {args[7:0], args[15:8], 5'h00, p, c});
	endtask
	task automatic finish_test();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			n_fail++;
			finish_test();
		end
	end
	initial begin
		rst_n_i = 1'b0;
		hsel_i = 1'b0;
		haddr_i = 32'h0;
		htrans_i = 2'h0;
		hwrite_i = 1'b0;
		hwdata_i = 32'h0;
		n_fail = 0;
		n_compared = 0;
		cycles = 0;
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		rchk(SCCL_ADDR_LINES, 32'hF0, "lines");
		for (int i = 0; i < 4; i++) rchk(SCCL_ADDR_CFG0 + 8'(4 * i), 32'h0, "cfg");
		cmd(SCCL_CMD_XLATE_CFG, 3'h2, 16'h2A41);
		rchk(SCCL_ADDR_CFG0 + 8'h04, 32'h412A, "cfg2");
		cmd(SCCL_CMD_XLATE_CFG, 3'h0, 16'h11FF);
		rchk(SCCL_ADDR_CFG0, 32'hFF11, "cfg1");
		rchk(SCCL_ADDR_CFG0 + 8'h04, 32'h412A, "cfg2");
		for (int i = 0; i < 15; i++) begin
			cmd(SCCL_CMD_XLATE_CFG, 3'h1, {tx_in[i][23:16], 8'h00});
			bus(1'b1, SCCL_ADDR_WSIZE, {30'h0, tx_in[i][9:8]});
			bus(1'b1, SCCL_ADDR_TXIN, {24'h0, tx_in[i][7:0]});
			bus(1'b0, SCCL_ADDR_TXOUT, 32'h0);
			// A dropped character leaves only the count meaningful.
			if (tx_exp[i][17:16] == 2'h0) rd = rd & 32'h30000;
			check("txout", tx_exp[i], rd);
		end
		for (int i = 0; i < 13; i++) begin
			cmd(SCCL_CMD_XLATE_CFG, 3'h1, {rx_in[i][31:24], rx_in[i][7:0]});
			bus(1'b1, SCCL_ADDR_WSIZE, {30'h0, rx_in[i][17:16]});
			bus(1'b1, SCCL_ADDR_RXIN, {24'h0, rx_in[i][15:8]});
			rchk(SCCL_ADDR_RXOUT, {23'h0, rx_exp[i]}, "rxout");
		end
		rchk(SCCL_ADDR_STATUS, 32'h2, "status");
		bus(1'b1, SCCL_ADDR_CTRL, 32'h2);
		rchk(SCCL_ADDR_STATUS, 32'h0, "status");
		for (int i = 0; i < 8; i++) begin
			cmd(SCCL_CMD_LINE_CTL, lc_in[i][10:8], {lc_in[i][7:0], 8'h00});
			rchk(SCCL_ADDR_LINES, {24'h0, lc_exp[i]}, "lines");
			rchk(SCCL_ADDR_STATUS, 32'h0, "status");
		end
		check("breaks", 32'hB, {28'h0, brk});
		bus(1'b1, SCCL_ADDR_CTRL, 32'h1);
		cmd(SCCL_CMD_LINE_CTL, 3'h1, 16'hC300);
		rchk(SCCL_ADDR_LINES, 32'hC6, "lines");
		rchk(SCCL_ADDR_STATUS, 32'h1, "status");
		cmd(SCCL_CMD_XLATE_CFG, 3'h1, 16'h2000);
		rchk(SCCL_ADDR_CFG0, 32'h28, "cfg1");
		bus(1'b1, SCCL_ADDR_CTRL, 32'h2);
		rchk(SCCL_ADDR_CTRL, 32'h0, "ctrl");
		rchk(SCCL_ADDR_LINES, 32'hC6, "lines");
		rchk(SCCL_ADDR_CFG0, 32'h28, "cfg1");
		cmd(SCCL_CMD_LINE_CTL, 3'h5, 16'h0300);
		rchk(SCCL_ADDR_STATUS, 32'h1, "status");
		rchk(SCCL_ADDR_LINES, 32'hC6, "lines");
		bus(1'b1, 8'hFC, 32'hFFFFFFFF);
		rchk(8'hFC, 32'h0, "unmapped");
		finish_test();
	end
endmodule
